// >>> core/fpc_consts.svh
// command codes, bus offsets and timing constants of the program command fsm
// assumes a 16-bit data bus and 12 low address bits decoded for command cycles
`ifndef FPC_CONSTS_SVH
`define FPC_CONSTS_SVH

// -----------------------------------------------------------------------------
// command offsets
// -----------------------------------------------------------------------------
`define FPC_ADDR_UNLK1   12'h555
`define FPC_ADDR_UNLK2   12'h2aa

// -----------------------------------------------------------------------------
// command data
// -----------------------------------------------------------------------------
`define FPC_D_UNLK1      16'h00aa
`define FPC_D_UNLK2      16'h0055
`define FPC_D_RESET      16'h00f0
`define FPC_D_SR_READ    16'h0070
`define FPC_D_SR_CLEAR   16'h0071
`define FPC_D_RESUME_A   16'h0030
`define FPC_D_RESUME_B   16'h0050
`define FPC_D_SUSPEND_A  16'h00b0
`define FPC_D_SUSPEND_B  16'h0051
`define FPC_D_EXIT_ENTRY 16'h0090
`define FPC_D_EXIT       16'h0000
`define FPC_D_LOCK_PROG  16'h00a0
`define FPC_D_PWD_COUNT  16'h0003

// -----------------------------------------------------------------------------
// timing and status register bits
// -----------------------------------------------------------------------------
`define FPC_CLK_MHZ      125
`define FPC_SUSP_LAT_NS  20000
`define FPC_SR_BUSY_BIT  7
`define FPC_SR_ABORT_BIT 1

`endif

// >>> core/fpc_pkg.sv
// types shared by the program command fsm and its bus front end
// assumes nothing beyond the constants header
package fpc_pkg;

  typedef enum logic [3:0] {
    read_array,
    program_busy,
    program_status_read,
    abort_unlock_first,
    abort_unlock_second,
    program_suspending,
    program_suspended,
    suspended_status_read,
    lockreg_mode,
    lockreg_program_entry,
    lockreg_programming,
    lockreg_status_read,
    lockreg_exit_pending
  } fpc_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        rd_end;
    logic [11:0] addr;
    logic [15:0] data;
  } fpc_cycle_t;

  typedef struct packed {
    logic suspend_req;
    logic resume_req;
    logic status_clear;
    logic lock_prog_start;
  } fpc_ctrl_t;

endpackage : fpc_pkg

// >>> core/fpc_bus_sync.sv
// front end: brings the asynchronous flash bus pins into clk and
// turns them into one-cycle write, read and read-end strobes
// assumes the host holds address and data stable around the we_n rising edge
`timescale 1ns/100ps
module fpc_bus_sync (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               srst,
  // flash bus pins
  input  wire logic               ce_n,
  input  wire logic               we_n,
  input  wire logic               oe_n,
  input  wire logic [11:0]        addr,
  input  wire logic [15:0]        dq_in,
  // decoded cycles
  output fpc_pkg::fpc_cycle_t     cycle
);

  // -----------------------------------------------------------------------------
  // two-stage synchronisers
  // -----------------------------------------------------------------------------
  logic [30:0] meta;
  logic [30:0] sync;
  logic        we_q;
  logic        oe_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta <= 31'h7;
      sync <= 31'h7;
    end else begin
      meta <= {dq_in, addr, oe_n, we_n, ce_n};
      sync <= meta;
    end
  end

  // -----------------------------------------------------------------------------
  // edge strobes, only sync stage is looked at
  // -----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      we_q  <= 1'b1;
      oe_q  <= 1'b1;
      cycle <= '0;
    end else begin
      we_q         <= sync[1];
      oe_q         <= sync[2];
      cycle.wr     <= sync[1] & ~we_q & ~sync[0];
      cycle.rd     <= ~sync[2] & oe_q & ~sync[0];
      cycle.rd_end <= sync[2] & ~oe_q;
      cycle.addr   <= sync[14:3];
      cycle.data   <= sync[30:15];
    end
  end

endmodule : fpc_bus_sync

// >>> core/fpc_cmd_fsm.sv
// program-related command state machine of a parallel nor flash
// assumes program, lock-register and status blocks elsewhere give the entry pulses,
// the done pulses and the status register value on clk
//
// Notes on behaviour
// - an embedded program finishing in program busy returns the machine to array read without any command.
// - in the first abort-unlock state 55h at 2AAh goes on, any other write goes back to program busy, reads stay.
// - in the second abort-unlock state F0h at 555h returns to array read, any other address or data goes to program busy.
// - a suspend request passes through a suspending state and settles into suspended within the suspend latency.
// - while suspended 70h at 555h gives one status read, 71h at 555h clears status, 30h or 50h resume programming.
// - in lock-register mode F0h reads array, A0h then any write starts a lock program, 90h enters exit where 0000h or 0003h reads array.
`timescale 1ns/100ps
`include "fpc_consts.svh"
module fpc_cmd_fsm #(
  parameter int SUSP_LAT_NS = `FPC_SUSP_LAT_NS
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               srst,
  // flash bus pins
  input  wire logic               ce_n,
  input  wire logic               we_n,
  input  wire logic               oe_n,
  input  wire logic [11:0]        addr,
  input  wire logic [15:0]        dq_in,
  output logic      [15:0]        dq_out,
  output logic                    dq_oe,
  // neighbouring blocks
  input  wire logic               prog_start,
  input  wire logic               prog_done,
  input  wire logic               lockreg_enter,
  input  wire logic               lock_prog_done,
  input  wire logic [7:0]         status,
  // state and requests
  output fpc_pkg::fpc_state_t     state,
  output fpc_pkg::fpc_ctrl_t      ctrl
);

  localparam int LAT_RAW = (SUSP_LAT_NS * `FPC_CLK_MHZ) / 1000;
  localparam int LAT_CYC = (LAT_RAW < 1) ? 1 : LAT_RAW;

  fpc_pkg::fpc_cycle_t cyc;
  fpc_pkg::fpc_state_t ret_state;
  fpc_pkg::fpc_state_t next_state;
  fpc_pkg::fpc_ctrl_t  next_ctrl;
  logic [31:0]         lat_cnt;
  logic                at555;
  logic                at2aa;
  logic                busy;
  logic                abort_flag;

  fpc_bus_sync u_sync (
    .clk   (clk),
    .srst  (srst),
    .ce_n  (ce_n),
    .we_n  (we_n),
    .oe_n  (oe_n),
    .addr  (addr),
    .dq_in (dq_in),
    .cycle (cyc)
  );

  assign at555      = cyc.addr == `FPC_ADDR_UNLK1;
  assign at2aa      = cyc.addr == `FPC_ADDR_UNLK2;
  assign busy       = ~status[`FPC_SR_BUSY_BIT];
  assign abort_flag = status[`FPC_SR_ABORT_BIT];

  // -----------------------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_ctrl  = '0;
    unique case (state)
      fpc_pkg::read_array: begin
        if (prog_start) begin
          next_state = fpc_pkg::program_busy;
        end else if (lockreg_enter) begin
          next_state = fpc_pkg::lockreg_mode;
        end
      end
      fpc_pkg::program_busy: begin
        if (prog_done) begin
          next_state = fpc_pkg::read_array;
        end else if (cyc.wr) begin
          if (at555 && cyc.data == `FPC_D_SR_READ) begin
            next_state = fpc_pkg::program_status_read;
          end else if (busy && (cyc.data == `FPC_D_SUSPEND_A || cyc.data == `FPC_D_SUSPEND_B)) begin
            next_state            = fpc_pkg::program_suspending;
            next_ctrl.suspend_req = 1'b1;
          end else if (!busy && abort_flag && at555 && cyc.data == `FPC_D_UNLK1) begin
            next_state = fpc_pkg::abort_unlock_first;
          end else if (!busy && abort_flag && cyc.data == `FPC_D_RESET) begin
            next_state = fpc_pkg::read_array;
          end else if (!busy && abort_flag && at555 && cyc.data == `FPC_D_SR_CLEAR) begin
            next_state             = fpc_pkg::read_array;
            next_ctrl.status_clear = 1'b1;
          end
        end
      end
      fpc_pkg::abort_unlock_first: begin
        if (cyc.wr) begin
          next_state = (at2aa && cyc.data == `FPC_D_UNLK2) ? fpc_pkg::abort_unlock_second
                                                           : fpc_pkg::program_busy;
        end
      end
      fpc_pkg::abort_unlock_second: begin
        if (cyc.wr) begin
          next_state = (at555 && cyc.data == `FPC_D_RESET) ? fpc_pkg::read_array
                                                           : fpc_pkg::program_busy;
        end
      end
      fpc_pkg::program_suspending: begin
        if (cyc.wr && at555 && cyc.data == `FPC_D_SR_READ) begin
          next_state = fpc_pkg::program_status_read;
        end else if (lat_cnt >= 32'(LAT_CYC - 1)) begin
          next_state = fpc_pkg::program_suspended;
        end
      end
      fpc_pkg::program_suspended: begin
        if (cyc.wr) begin
          if (at555 && cyc.data == `FPC_D_SR_READ) begin
            next_state = fpc_pkg::suspended_status_read;
          end else if (at555 && cyc.data == `FPC_D_SR_CLEAR) begin
            next_ctrl.status_clear = 1'b1;
          end else if (cyc.data == `FPC_D_RESUME_A || cyc.data == `FPC_D_RESUME_B) begin
            next_state           = fpc_pkg::program_busy;
            next_ctrl.resume_req = 1'b1;
          end
        end
      end
      fpc_pkg::lockreg_mode: begin
        if (cyc.wr) begin
          if (cyc.data == `FPC_D_RESET) begin
            next_state = fpc_pkg::read_array;
          end else if (at555 && cyc.data == `FPC_D_SR_READ) begin
            next_state = fpc_pkg::lockreg_status_read;
          end else if (at555 && cyc.data == `FPC_D_SR_CLEAR) begin
            next_ctrl.status_clear = 1'b1;
          end else if (cyc.data == `FPC_D_EXIT_ENTRY) begin
            next_state = fpc_pkg::lockreg_exit_pending;
          end else if (cyc.data == `FPC_D_LOCK_PROG) begin
            next_state = fpc_pkg::lockreg_program_entry;
          end
        end
      end
      fpc_pkg::lockreg_program_entry: begin
        if (cyc.wr) begin
          next_state                = fpc_pkg::lockreg_programming;
          next_ctrl.lock_prog_start = 1'b1;
        end
      end
      fpc_pkg::lockreg_programming: begin
        if (lock_prog_done) begin
          next_state = fpc_pkg::lockreg_mode;
        end else if (cyc.wr && at555 && cyc.data == `FPC_D_SR_READ) begin
          next_state = fpc_pkg::lockreg_status_read;
        end
      end
      fpc_pkg::lockreg_exit_pending: begin
        if (cyc.wr && (cyc.data == `FPC_D_EXIT || cyc.data == `FPC_D_PWD_COUNT)) begin
          next_state = fpc_pkg::read_array;
        end
      end
      fpc_pkg::program_status_read, fpc_pkg::suspended_status_read, fpc_pkg::lockreg_status_read: begin
        if (cyc.rd) begin
          next_state = ret_state;
        end
      end
      default: begin
        next_state = fpc_pkg::read_array;
      end
    endcase
  end

  // -----------------------------------------------------------------------------
  // state, return state and request pulses
  // -----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= fpc_pkg::read_array;
      ctrl  <= '0;
    end else begin
      state <= next_state;
      ctrl  <= next_ctrl;
    end
  end

  // remembered on entry so the single status read hands back the old state
  always_ff @(posedge clk) begin
    if (srst) begin
      ret_state <= fpc_pkg::read_array;
    end else if (next_state != state && next_state inside {fpc_pkg::program_status_read,
                 fpc_pkg::suspended_status_read, fpc_pkg::lockreg_status_read}) begin
      ret_state <= state;
    end
  end

  // -----------------------------------------------------------------------------
  // suspend latency counter
  // -----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || state != fpc_pkg::program_suspending) begin
      lat_cnt <= '0;
    end else begin
      lat_cnt <= lat_cnt + 32'h1;
    end
  end

  // -----------------------------------------------------------------------------
  // status read drive: held for the read cycle only, other reads belong to the array path
  // -----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      dq_out <= '0;
      dq_oe  <= 1'b0;
    end else if (cyc.rd && state inside {fpc_pkg::program_status_read, fpc_pkg::suspended_status_read,
                                         fpc_pkg::lockreg_status_read}) begin
      dq_out <= {8'h00, status};
      dq_oe  <= 1'b1;
    end else if (cyc.rd_end) begin
      dq_oe  <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------------
  a_prog_done_read: assert property (@(posedge clk) disable iff (srst)
    (state == fpc_pkg::program_busy && prog_done) |=> state == fpc_pkg::read_array)
    else $error("program done did not return to array read");

  a_unlock1_next: assert property (@(posedge clk) disable iff (srst)
    (state == fpc_pkg::abort_unlock_first && cyc.wr) |=>
      (state == ($past(at2aa && cyc.data == `FPC_D_UNLK2) ? fpc_pkg::abort_unlock_second
                                                           : fpc_pkg::program_busy)))
    else $error("first abort unlock went to the wrong state");

  a_unlock1_read: assert property (@(posedge clk) disable iff (srst)
    (state == fpc_pkg::abort_unlock_first && !cyc.wr) |=> state == fpc_pkg::abort_unlock_first)
    else $error("first abort unlock left without a write");

  a_unlock2_next: assert property (@(posedge clk) disable iff (srst)
    (state == fpc_pkg::abort_unlock_second && cyc.wr) |=>
      (state == ($past(at555 && cyc.data == `FPC_D_RESET) ? fpc_pkg::read_array
                                                          : fpc_pkg::program_busy)))
    else $error("second abort unlock went to the wrong state");

  a_suspend_settle: assert property (@(posedge clk) disable iff (srst)
    (state == fpc_pkg::program_suspending) |-> lat_cnt < 32'(LAT_CYC))
    else $error("suspend latency overrun");

  a_resume_prog: assert property (@(posedge clk) disable iff (srst)
    (state == fpc_pkg::program_suspended && cyc.wr &&
     (cyc.data == `FPC_D_RESUME_A || cyc.data == `FPC_D_RESUME_B) && !at555)
      |=> state == fpc_pkg::program_busy && ctrl.resume_req)
    else $error("resume did not restart programming");

  a_clear_pulse: assert property (@(posedge clk) disable iff (srst)
    (state == fpc_pkg::program_suspended && cyc.wr && at555 && cyc.data == `FPC_D_SR_CLEAR)
      |=> ctrl.status_clear && state == fpc_pkg::program_suspended)
    else $error("status clear missing while suspended");

  a_lock_exit: assert property (@(posedge clk) disable iff (srst)
    (state == fpc_pkg::lockreg_exit_pending && cyc.wr &&
     (cyc.data == `FPC_D_EXIT || cyc.data == `FPC_D_PWD_COUNT)) |=> state == fpc_pkg::read_array)
    else $error("lock register exit failed");

  a_sr_one_read: assert property (@(posedge clk) disable iff (srst)
    (state inside {fpc_pkg::program_status_read, fpc_pkg::suspended_status_read,
                   fpc_pkg::lockreg_status_read} && cyc.rd)
      |=> state == $past(ret_state) ##0 dq_oe)
    else $error("status read did not return after one read");

  c_abort_seq: cover property (@(posedge clk) disable iff (srst)
    state == fpc_pkg::abort_unlock_second ##1 state == fpc_pkg::read_array);
  c_suspend:   cover property (@(posedge clk) disable iff (srst)
    state == fpc_pkg::program_suspending ##1 state == fpc_pkg::program_suspended);
  c_lock_prog: cover property (@(posedge clk) disable iff (srst)
    state == fpc_pkg::lockreg_program_entry ##1 state == fpc_pkg::lockreg_programming);
  c_status:    cover property (@(posedge clk) disable iff (srst)
    state == fpc_pkg::suspended_status_read ##1 state == fpc_pkg::program_suspended);

endmodule : fpc_cmd_fsm

// >>> dv/fpc_host_model.sv
// host memory controller model: drives write and read cycles on the flash bus pins
// assumes clk is the device clock; pins change only just after a rising edge
`timescale 1ns/100ps
module fpc_host_model (
  // clock
  input  wire logic        clk,
  // device answer
  input  wire logic [15:0] dq_out,
  input  wire logic        dq_oe,
  // flash bus pins
  output logic             ce_n,
  output logic             we_n,
  output logic             oe_n,
  output logic      [11:0] addr,
  output logic      [15:0] dq
);
  initial begin
    ce_n = 1'b1;
    we_n = 1'b1;
    oe_n = 1'b1;
    addr = 12'h000;
    dq   = 16'hffff;
  end

  // ---------------------------------------------------------------------------
  // write cycle
  // ---------------------------------------------------------------------------
  // we_n low 3 clk then high 7 clk, data held 4 clk past we_n rising
  task automatic bus_write(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    ce_n <= 1'b0;
    addr <= a;
    dq   <= d;
    we_n <= 1'b0;
    repeat (3) @(posedge clk);
    we_n <= 1'b1;
    repeat (4) @(posedge clk);
    ce_n <= 1'b1;
    // released lines show the inverse so a stale value never looks valid
    addr <= ~a;
    dq   <= ~d;
    repeat (3) @(posedge clk);
  endtask : bus_write

  // ---------------------------------------------------------------------------
  // read cycle
  // ---------------------------------------------------------------------------
  task automatic bus_read(output logic oe_seen, output logic [15:0] d_seen);
    @(posedge clk);
    ce_n <= 1'b0;
    oe_n <= 1'b0;
    repeat (7) @(posedge clk);
    oe_seen = dq_oe;
    d_seen  = dq_out;
    oe_n <= 1'b1;
    ce_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : bus_read
endmodule : fpc_host_model

// >>> dv/tb_top.sv
// self-checking bench of the program command fsm
// assumes the fsm answers within 7 clk of we_n rising and a short suspend latency
`timescale 1ns/100ps
module tb_top;
  localparam int LAT_NS  = 80;
  localparam int LAT_CYC = LAT_NS / 8;

  typedef struct {
    fpc_pkg::fpc_state_t start;
    logic [11:0]         a;
    logic [15:0]         d;
    fpc_pkg::fpc_state_t st;
    logic [3:0]          ct;
  } fpc_row_t;

  logic                clk, srst, prog_start, prog_done, lockreg_enter, lock_prog_done;
  logic                ce_n, we_n, oe_n, dq_oe, oe_seen;
  logic [11:0]         addr;
  logic [15:0]         dq, dq_out, d_seen;
  logic [7:0]          status;
  fpc_pkg::fpc_state_t state;
  fpc_pkg::fpc_ctrl_t  ctrl;
  logic [3:0]          ctrl_seen = 4'h0;
  logic                seen_clr = 1'b0;
  int                  fail_count, n_compared;
  int                  cyc = 0;
  fpc_row_t            rows[19];

  fpc_host_model u_host (.clk(clk), .dq_out(dq_out), .dq_oe(dq_oe), .ce_n(ce_n), .we_n(we_n),
                         .oe_n(oe_n), .addr(addr), .dq(dq));
  fpc_cmd_fsm #(.SUSP_LAT_NS(LAT_NS)) u_dut (
    .clk(clk), .srst(srst), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_in(dq),
    .dq_out(dq_out), .dq_oe(dq_oe), .prog_start(prog_start), .prog_done(prog_done),
    .lockreg_enter(lockreg_enter), .lock_prog_done(lock_prog_done), .status(status),
    .state(state), .ctrl(ctrl));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ctrl pulses last one cycle, so they are gathered until cleared
  always @(posedge clk) begin
    ctrl_seen <= seen_clr ? ctrl : (ctrl_seen | ctrl);
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task automatic do_reset(input int n);
    @(posedge clk) srst <= 1'b1;
    repeat (n) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : do_reset

  task automatic pulse(input int which);
    @(posedge clk);
    if (which == 0) prog_start <= 1'b1;
    if (which == 1) prog_done <= 1'b1;
    if (which == 2) lockreg_enter <= 1'b1;
    if (which == 3) lock_prog_done <= 1'b1;
    @(posedge clk);
    {prog_start, prog_done, lockreg_enter, lock_prog_done} <= 4'h0;
    repeat (2) @(posedge clk);
  endtask : pulse

  // drives the machine from reset into the wanted start state
  task automatic goto(input fpc_pkg::fpc_state_t s);
    do_reset(4);
    status <= (s == fpc_pkg::program_suspended) ? 8'h00 : 8'h82;
    if (s inside {fpc_pkg::abort_unlock_first, fpc_pkg::abort_unlock_second, fpc_pkg::program_suspended,
                  fpc_pkg::program_busy})
      pulse(0);
    if (s inside {fpc_pkg::abort_unlock_first, fpc_pkg::abort_unlock_second})
      u_host.bus_write(12'h555, 16'h00aa);
    if (s == fpc_pkg::abort_unlock_second)
      u_host.bus_write(12'h2aa, 16'h0055);
    if (s == fpc_pkg::program_suspended) begin
      u_host.bus_write(12'h000, 16'h00b0);
      repeat (LAT_CYC + 4) @(posedge clk);
    end
    if (s inside {fpc_pkg::lockreg_mode, fpc_pkg::lockreg_exit_pending, fpc_pkg::lockreg_program_entry})
      pulse(2);
    if (s == fpc_pkg::lockreg_exit_pending)
      u_host.bus_write(12'h000, 16'h0090);
    if (s == fpc_pkg::lockreg_program_entry)
      u_host.bus_write(12'h000, 16'h00a0);
  endtask : goto

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {srst, prog_start, prog_done, lockreg_enter, lock_prog_done} = 5'h10;
    status = 8'h00;
    fail_count = 0;
    n_compared = 0;
    rows = '{
      '{fpc_pkg::abort_unlock_first, 12'h2aa, 16'h0055, fpc_pkg::abort_unlock_second, 4'h0},
      '{fpc_pkg::abort_unlock_first, 12'h555, 16'h0055, fpc_pkg::program_busy, 4'h0},
      '{fpc_pkg::abort_unlock_first, 12'h2aa, 16'h0056, fpc_pkg::program_busy, 4'h0},
      '{fpc_pkg::abort_unlock_second, 12'h555, 16'h00f0, fpc_pkg::read_array, 4'h0},
      '{fpc_pkg::abort_unlock_second, 12'h554, 16'h00f0, fpc_pkg::program_busy, 4'h0},
      '{fpc_pkg::abort_unlock_second, 12'h555, 16'h00f1, fpc_pkg::program_busy, 4'h0},
      '{fpc_pkg::program_suspended, 12'h123, 16'h0030, fpc_pkg::program_busy, 4'h4},
      '{fpc_pkg::program_suspended, 12'h000, 16'h0050, fpc_pkg::program_busy, 4'h4},
      '{fpc_pkg::program_suspended, 12'h555, 16'h0071, fpc_pkg::program_suspended, 4'h2},
      '{fpc_pkg::lockreg_mode, 12'h123, 16'h00f0, fpc_pkg::read_array, 4'h0},
      '{fpc_pkg::lockreg_mode, 12'h000, 16'h00a0, fpc_pkg::lockreg_program_entry, 4'h0},
      '{fpc_pkg::lockreg_mode, 12'h000, 16'h0090, fpc_pkg::lockreg_exit_pending, 4'h0},
      '{fpc_pkg::lockreg_exit_pending, 12'h000, 16'h0000, fpc_pkg::read_array, 4'h0},
      '{fpc_pkg::lockreg_exit_pending, 12'h000, 16'h0003, fpc_pkg::read_array, 4'h0},
      '{fpc_pkg::lockreg_exit_pending, 12'h000, 16'h0001, fpc_pkg::lockreg_exit_pending, 4'h0},
      '{fpc_pkg::lockreg_program_entry, 12'h000, 16'h1234, fpc_pkg::lockreg_programming, 4'h1},
      '{fpc_pkg::program_busy, 12'h555, 16'h0070, fpc_pkg::program_status_read, 4'h0},
      '{fpc_pkg::lockreg_mode, 12'h555, 16'h0070, fpc_pkg::lockreg_status_read, 4'h0},
      '{fpc_pkg::lockreg_mode, 12'h555, 16'h0071, fpc_pkg::lockreg_mode, 4'h2}
    };
    do_reset(12);
    check({12'h000, state}, {12'h000, fpc_pkg::read_array});
    check({15'h0000, dq_oe}, 16'h0000);
    check({12'h000, ctrl}, 16'h0000);

    foreach (rows[i]) begin
      goto(rows[i].start);
      seen_clr <= 1'b1;
      @(posedge clk) seen_clr <= 1'b0;
      u_host.bus_write(rows[i].a, rows[i].d);
      check({12'h000, state}, {12'h000, rows[i].st});
      check({12'h000, ctrl_seen}, {12'h000, rows[i].ct});
    end

    // finished program returns to array read unprompted
    goto(fpc_pkg::abort_unlock_first);
    u_host.bus_read(oe_seen, d_seen);
    check({12'h000, state}, {12'h000, fpc_pkg::abort_unlock_first});
    u_host.bus_write(12'h2aa, 16'h0000);
    pulse(1);
    check({12'h000, state}, {12'h000, fpc_pkg::read_array});

    // suspend passes through suspending, settles only after the latency
    goto(fpc_pkg::lockreg_mode);
    do_reset(4);
    status <= 8'h00;
    pulse(0);
    seen_clr <= 1'b1;
    @(posedge clk) seen_clr <= 1'b0;
    u_host.bus_write(12'h3c3, 16'h0051);
    check({12'h000, state}, {12'h000, fpc_pkg::program_suspending});
    check({12'h000, ctrl_seen}, 16'h0008);
    repeat (LAT_CYC + 2) @(posedge clk);
    check({12'h000, state}, {12'h000, fpc_pkg::program_suspended});

    // status read answers on exactly one read, then the state comes back
    status <= 8'h42;
    u_host.bus_write(12'h555, 16'h0070);
    check({12'h000, state}, {12'h000, fpc_pkg::suspended_status_read});
    u_host.bus_read(oe_seen, d_seen);
    check({15'h0000, oe_seen}, 16'h0001);
    check(d_seen, 16'h0042);
    check({12'h000, state}, {12'h000, fpc_pkg::program_suspended});
    u_host.bus_read(oe_seen, d_seen);
    check({15'h0000, oe_seen}, 16'h0000);

    // lock program completes back into lock-register mode
    goto(fpc_pkg::lockreg_program_entry);
    u_host.bus_write(12'h000, 16'h0001);
    pulse(3);
    check({12'h000, state}, {12'h000, fpc_pkg::lockreg_mode});
    wrap_up();
  end
endmodule : tb_top
